// file: design/drs_consts.svh
`ifndef DRS_CONSTS_SVH
`define DRS_CONSTS_SVH

// byte offsets on the apb bus
`define DRS_OFF_CONTROL 12'h000
`define DRS_OFF_STATUS 12'h004
`define DRS_OFF_EVENT 12'h008
`define DRS_OFF_MASK 12'h00C
`define DRS_OFF_TIMER 12'h010
`define DRS_OFF_HWCFG 12'h014
`define DRS_OFF_CPU_IRQ_EN 12'h018
`define DRS_OFF_CPU_IRQ 12'h01C
`define DRS_OFF_POWER 12'h020

// control register fields
`define DRS_CTL_DRV_VBUS 0
`define DRS_CTL_CHRG_VBUS 1
`define DRS_CTL_DISCHRG_VBUS 2
`define DRS_CTL_DP_PULLDOWN 3
`define DRS_CTL_DP_PULLUP 4
`define DRS_CTL_DM_PULLDOWN 5
`define DRS_CTL_SRP_SEL 9
`define DRS_CTL_SRP_DET_EN 10
`define DRS_CTL_WIDTH 11

// status / event bit positions
`define DRS_ST_ID 0
`define DRS_ST_A_VBUS_VLD 1
`define DRS_ST_B_SESS_END 2
`define DRS_ST_A_SESS_VLD 3
`define DRS_ST_B_SESS_VLD 4
`define DRS_ST_OVERCUR 5
`define DRS_ST_SE0 6
`define DRS_ST_J 7
`define DRS_ST_SUSPEND 8
`define DRS_ST_WIDTH 9
`define DRS_EV_SRP_DET 9
`define DRS_EV_TIMEOUT 10
`define DRS_EV_WIDTH 11

// hardware configuration and cpu irq fields
`define DRS_HW_PIN_EN 0
`define DRS_HW_EDGE 1
`define DRS_HW_ACT_HIGH 2
`define DRS_CPU_ROLE_BIT 9
`define DRS_RST_HWCFG 3'h0

// timing
`define DRS_CLK_HZ 50000000
`define DRS_TICK_NS 10000
`define DRS_CLK_NS 20
`define DRS_TICK_CYC (`DRS_TICK_NS / `DRS_CLK_NS)
`define DRS_IDLE_US 3000
`define DRS_IDLE_CYC (`DRS_IDLE_US * 1000 / `DRS_CLK_NS)
`define DRS_TIMER_WIDTH 16

`endif

// file: design/drs_pkg.sv
package drs_pkg;

    typedef struct packed {
        logic drv_vbus;
        logic chrg_vbus;
        logic dischrg_vbus;
        logic dp_pulldown;
        logic dp_pullup;
        logic dm_pulldown;
        logic srp_det_en;
        logic srp_sel_dline;
    } drs_phy_ctl_type;

    typedef struct packed {
        logic id;
        logic a_vbus_vld;
        logic b_sess_end;
        logic a_sess_vld;
        logic b_sess_vld;
        logic overcur;
        logic dp;
        logic dm;
        logic vbus_pulse;
        logic dline_pulse;
    } drs_phy_stat_type;

    typedef enum logic [2:0] {
        DRS_AWAKE = 3'b001,
        DRS_SLEEP = 3'b010,
        DRS_WAKING = 3'b100
    } drs_pwr_type;

endpackage

// file: design/drs_dual_role.sv
// What this block does
// - peripheral releases pullup after 3 ms idle
// - suspended host treats SE0 as swap request
// - host connects pullup within 3 ms
// - peripheral waits 30 us, then sees J
// - new host drives reset within 1 ms
// - temporary host stops, may reconnect pullup
// - host drops pullup after 3 ms idle
// - host waits 30 us, confirms J, resets
// - all role inputs visible in event/status
// - one programmable timer for role timeouts
// - timer ticks 0.01 ms, expiry raises event
// - status change latches event, per-bit mask
// - control drives phy, status reports lines
// - shared pin, polarity and edge configurable
// - pin needs mask, role enable, pin enable
// - role enable and summary at bit 9
// - config bit 0 gates the pin
// - power saving only outside a session
// - slow clock keeps wake detection alive
// - masked-in id, b_sess_vld and srp events wake the chip
// - any register access wakes the chip
// - srp detect enable bit 10, select bit 9
// - control bit 4 drives local pullup
//
// Our own choices: the address map and the APB register port.
`include "drs_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module drs_dual_role
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire drs_pkg::drs_phy_stat_type phy_stat,
    input wire logic host_core_irq,
    input wire logic slow_wake_clock_tick,
    output drs_pkg::drs_phy_ctl_type phy_ctl,
    output logic shared_irq_pin,
    output logic power_down,
    output logic local_dp_pullup
);

    logic [`DRS_CTL_WIDTH-1:0] dual_role_control_reg_r;
    logic [`DRS_ST_WIDTH-1:0] dual_role_status_reg_r;
    logic [`DRS_EV_WIDTH-1:0] dual_role_event_reg_r;
    logic [`DRS_EV_WIDTH-1:0] dual_role_event_reg_nxt;
    logic [`DRS_EV_WIDTH-1:0] dual_role_event_mask_reg_r;
    logic [`DRS_TIMER_WIDTH-1:0] dual_role_tick_timer_r;
    logic [15:0] tick_div_r;
    logic [2:0] host_hw_config_reg_r;
    logic cpu_irq_enable_reg_r;
    logic [21:0] idle_cnt_r;
    logic se0_suspended_r;
    logic vbus_pulse_d_r;
    logic dline_pulse_d_r;
    logic irq_d_r;
    logic [31:0] prdata_r;
    logic [`DRS_EV_WIDTH-1:0] wake_mask_r;
    drs_pkg::drs_pwr_type pwr_r;
    drs_pkg::drs_pwr_type pwr_nxt;
    logic pready_r;

    // writes land on the edge that samples pready high, not one edge earlier
    wire wr_en = psel && penable && pwrite && pready_r;
    wire rd_en = psel && penable && !pwrite;
    wire hit_ctl = paddr == `DRS_OFF_CONTROL;
    wire hit_st = paddr == `DRS_OFF_STATUS;
    wire hit_ev = paddr == `DRS_OFF_EVENT;
    wire hit_mask = paddr == `DRS_OFF_MASK;
    wire hit_tmr = paddr == `DRS_OFF_TIMER;
    wire hit_hw = paddr == `DRS_OFF_HWCFG;
    wire hit_cen = paddr == `DRS_OFF_CPU_IRQ_EN;
    wire hit_cirq = paddr == `DRS_OFF_CPU_IRQ;
    wire hit_pwr = paddr == `DRS_OFF_POWER;
    wire hit_any = hit_ctl | hit_st | hit_ev | hit_mask | hit_tmr | hit_hw | hit_cen
        | hit_cirq | hit_pwr;

    // bus activity means no SE0 and no idle J held; simple line-state monitor
    wire se0_now = !phy_stat.dp && !phy_stat.dm;
    wire j_now = phy_stat.dp && !phy_stat.dm;
    wire idle_3ms = idle_cnt_r >= 22'(`DRS_IDLE_CYC);
    wire in_session = phy_stat.a_sess_vld || phy_stat.b_sess_vld;

    wire [`DRS_ST_WIDTH-1:0] status_now = {idle_3ms, j_now, se0_now,
        phy_stat.overcur, phy_stat.b_sess_vld, phy_stat.a_sess_vld,
        phy_stat.b_sess_end, phy_stat.a_vbus_vld, phy_stat.id};

    // srp detect: method selected by bit 9, enabled by bit 10
    wire srp_src = dual_role_control_reg_r[`DRS_CTL_SRP_SEL] ?
        (phy_stat.dline_pulse && !dline_pulse_d_r) : (phy_stat.vbus_pulse && !vbus_pulse_d_r);
    wire srp_evt = dual_role_control_reg_r[`DRS_CTL_SRP_DET_EN] && srp_src;

    wire tick = tick_div_r == 16'(`DRS_TICK_CYC - 1);
    wire timer_fire = tick && dual_role_tick_timer_r == 16'h0001;

    wire [`DRS_EV_WIDTH-1:0] ev_set = {timer_fire, srp_evt,
        status_now ^ dual_role_status_reg_r};
    wire [`DRS_EV_WIDTH-1:0] ev_clr = (wr_en && hit_ev) ?
        pwdata[`DRS_EV_WIDTH-1:0] : {`DRS_EV_WIDTH{1'b0}};

    always_comb
    begin
        // set wins over a simultaneous write-one-to-clear
        dual_role_event_reg_nxt = (dual_role_event_reg_r & ~ev_clr) | ev_set;
    end

    wire role_pending = |(dual_role_event_reg_r & dual_role_event_mask_reg_r);
    wire role_summary = role_pending;
    wire irq_active = ((role_summary && cpu_irq_enable_reg_r) || host_core_irq)
        && host_hw_config_reg_r[`DRS_HW_PIN_EN];
    wire irq_edge_mode = host_hw_config_reg_r[`DRS_HW_EDGE];
    wire irq_raw = irq_edge_mode ? (irq_active && !irq_d_r) : irq_active;
    // wake events: id change, b_sess_vld change, srp, using mask latched at sleep entry
    wire wake_evt = |(ev_set & wake_mask_r & {1'b0, 1'b1, 4'h0, 1'b1, 3'h0, 1'b1});
    wire sleep_req = wr_en && hit_pwr && pwdata[0];

    always_comb
    begin
        pwr_nxt = pwr_r;
        case (pwr_r)
            drs_pkg::DRS_AWAKE:
                if (sleep_req && !in_session)
                    pwr_nxt = drs_pkg::DRS_SLEEP;
            drs_pkg::DRS_SLEEP:
                // any bus access, or a masked-in id, b_sess_vld or srp event on a slow tick, restarts the clocks
                if (psel || (slow_wake_clock_tick && wake_evt))
                    pwr_nxt = drs_pkg::DRS_WAKING;
            drs_pkg::DRS_WAKING:
                pwr_nxt = drs_pkg::DRS_AWAKE;
            default:
                pwr_nxt = drs_pkg::DRS_AWAKE;
        endcase
    end

    wire [31:0] rd_mux =
        hit_ctl ? 32'(dual_role_control_reg_r) :
        hit_st ? 32'(dual_role_status_reg_r) :
        hit_ev ? 32'(dual_role_event_reg_r) :
        hit_mask ? 32'(dual_role_event_mask_reg_r) :
        hit_tmr ? 32'(dual_role_tick_timer_r) :
        hit_hw ? 32'(host_hw_config_reg_r) :
        hit_cen ? (32'(cpu_irq_enable_reg_r) << `DRS_CPU_ROLE_BIT) :
        hit_cirq ? (32'(role_summary) << `DRS_CPU_ROLE_BIT) :
        hit_pwr ? 32'(pwr_r == drs_pkg::DRS_SLEEP) : 32'h00000000;

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            dual_role_control_reg_r <= 11'h000;
            dual_role_event_mask_reg_r <= 11'h000;
            host_hw_config_reg_r <= `DRS_RST_HWCFG;
            cpu_irq_enable_reg_r <= 1'b0;
        end
        else if (wr_en)
        begin
            if (hit_ctl)
                dual_role_control_reg_r <= pwdata[`DRS_CTL_WIDTH-1:0];
            if (hit_mask)
                dual_role_event_mask_reg_r <= pwdata[`DRS_EV_WIDTH-1:0];
            if (hit_hw)
                host_hw_config_reg_r <= pwdata[2:0];
            if (hit_cen)
                cpu_irq_enable_reg_r <= pwdata[`DRS_CPU_ROLE_BIT];
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            dual_role_status_reg_r <= 9'h000;
            dual_role_event_reg_r <= 11'h000;
            vbus_pulse_d_r <= 1'b0;
            dline_pulse_d_r <= 1'b0;
        end
        else
        begin
            dual_role_status_reg_r <= status_now;
            dual_role_event_reg_r <= dual_role_event_reg_nxt;
            vbus_pulse_d_r <= phy_stat.vbus_pulse;
            dline_pulse_d_r <= phy_stat.dline_pulse;
        end
    end

    // timer: a write loads and restarts; zero stops it
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            dual_role_tick_timer_r <= 16'h0000;
            tick_div_r <= 16'h0000;
        end
        else if (wr_en && hit_tmr)
        begin
            dual_role_tick_timer_r <= pwdata[`DRS_TIMER_WIDTH-1:0];
            tick_div_r <= 16'h0000;
        end
        else
        begin
            tick_div_r <= tick ? 16'h0000 : tick_div_r + 16'h0001;
            if (tick && dual_role_tick_timer_r != 16'h0000)
                dual_role_tick_timer_r <= dual_role_tick_timer_r - 16'h0001;
        end
    end

    // idle monitor: counts cycles with the J and SE0 status bits held without change
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            idle_cnt_r <= 22'h000000;
            se0_suspended_r <= 1'b0;
        end
        else
        begin
            if (status_now[`DRS_ST_J:`DRS_ST_SE0] != dual_role_status_reg_r[`DRS_ST_J:`DRS_ST_SE0])
                idle_cnt_r <= 22'h000000;
            else if (!idle_3ms)
                idle_cnt_r <= idle_cnt_r + 22'h000001;
            // SE0 after suspend reads as swap request, not disconnect
            se0_suspended_r <= idle_3ms && se0_now;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            pwr_r <= drs_pkg::DRS_AWAKE;
            wake_mask_r <= 11'h000;
            irq_d_r <= 1'b0;
            prdata_r <= 32'h00000000;
            shared_irq_pin <= 1'b1;
        end
        else
        begin
            pwr_r <= pwr_nxt;
            if (pwr_r == drs_pkg::DRS_AWAKE && pwr_nxt == drs_pkg::DRS_SLEEP)
                wake_mask_r <= dual_role_event_mask_reg_r;
            irq_d_r <= irq_active;
            if (rd_en && !pready_r)
                prdata_r <= rd_mux;
            // default polarity is active low
            shared_irq_pin <= host_hw_config_reg_r[`DRS_HW_ACT_HIGH] ? irq_raw : !irq_raw;
        end
    end

    // handshake in the access phase: one wait state gives registered read data
    always_ff @(posedge clk)
    begin
        if (reset)
            pready_r <= 1'b0;
        else
            pready_r <= psel && penable && !pready_r;
    end

    assign pready = pready_r;
    assign pslverr = pready_r && !hit_any;
    assign prdata = prdata_r;
    assign power_down = pwr_r == drs_pkg::DRS_SLEEP;
    // software runs the role swap through bit 4; SE0 swap request has no status bit of its own, only the SE0 and suspend bits
    assign local_dp_pullup = dual_role_control_reg_r[`DRS_CTL_DP_PULLUP];
    assign phy_ctl = '{
        drv_vbus: dual_role_control_reg_r[`DRS_CTL_DRV_VBUS] && !power_down,
        chrg_vbus: dual_role_control_reg_r[`DRS_CTL_CHRG_VBUS],
        dischrg_vbus: dual_role_control_reg_r[`DRS_CTL_DISCHRG_VBUS],
        dp_pulldown: dual_role_control_reg_r[`DRS_CTL_DP_PULLDOWN],
        dp_pullup: dual_role_control_reg_r[`DRS_CTL_DP_PULLUP],
        dm_pulldown: dual_role_control_reg_r[`DRS_CTL_DM_PULLDOWN],
        srp_det_en: dual_role_control_reg_r[`DRS_CTL_SRP_DET_EN],
        srp_sel_dline: dual_role_control_reg_r[`DRS_CTL_SRP_SEL]
    };

endmodule

`default_nettype wire

// file: tb/drs_dual_role_chk.sv
`timescale 1ns/100ps
`default_nettype none

module drs_dual_role_chk
(
    input wire logic clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire drs_pkg::drs_phy_ctl_type phy_ctl,
    input wire logic shared_irq_pin,
    input wire logic power_down,
    input wire logic local_dp_pullup
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    // only setups that start awake; pready does not depend on the power state
    ready_wait_a: assert property (psel && !penable && !power_down ##1 penable |=> pready)
        else $error("ready missing one cycle into access");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready stood longer than one cycle");
    error_ready_a: assert property (pslverr |-> pready)
        else $error("error flag without ready");
    refused_read_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read returned data");
    pullup_follow_a: assert property (local_dp_pullup == phy_ctl.dp_pullup)
        else $error("pull-up pin differs from control");
    sleep_vbus_a: assert property (power_down |-> !phy_ctl.drv_vbus)
        else $error("bus power driven while sleeping");
    select_wake_a: assert property (power_down && psel |-> ##[1:4] !power_down)
        else $error("select did not wake the block");
    reset_quiet_a: assert property (@(posedge clk) disable iff (1'b0)
        reset |=> shared_irq_pin && !power_down && phy_ctl == '0)
        else $error("outputs not quiet after reset");

    cover property (pready && pslverr);
    cover property ($rose(power_down));
    cover property ($fell(shared_irq_pin));
endmodule

bind drs_dual_role drs_dual_role_chk i_drs_dual_role_chk (.clk(clk), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .phy_ctl(phy_ctl), .shared_irq_pin(shared_irq_pin),
    .power_down(power_down), .local_dp_pullup(local_dp_pullup));

`default_nettype wire

// file: tb/drs_peer.sv
`timescale 1ns/100ps
`default_nettype none

// far-side device seen through the bus lines and bus power
module drs_peer
(
    input wire drs_pkg::drs_phy_ctl_type phy_ctl,
    input wire logic peer_pullup,
    input wire logic peer_vbus,
    input wire logic peer_id,
    output drs_pkg::drs_phy_stat_type phy_stat
);
    logic vbus_on;
    assign vbus_on = phy_ctl.drv_vbus | peer_vbus;
    assign phy_stat.id = peer_id;
    assign phy_stat.a_vbus_vld = vbus_on;
    assign phy_stat.a_sess_vld = vbus_on;
    assign phy_stat.b_sess_vld = vbus_on;
    assign phy_stat.b_sess_end = ~vbus_on;
    assign phy_stat.overcur = 1'b0;
    // either pull-up raises dp; released lines fall to se0
    assign phy_stat.dp = phy_ctl.dp_pullup | peer_pullup;
    assign phy_stat.dm = 1'b0;
    assign phy_stat.vbus_pulse = 1'b0;
    assign phy_stat.dline_pulse = 1'b0;
endmodule

`default_nettype wire

// file: tb/drs_dual_role_test.sv
`timescale 1ns/100ps
`default_nettype none

module drs_dual_role_test;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, shared_irq_pin, power_down, local_dp_pullup;
    drs_pkg::drs_phy_stat_type phy_stat;
    drs_pkg::drs_phy_ctl_type phy_ctl;
    logic host_core_irq = 1'b0;
    logic slow_tick = 1'b1;
    logic peer_pullup = 1'b1;
    logic peer_vbus = 1'b0;
    logic peer_id = 1'b1;
    logic [31:0] rd;
    logic er;
    int fail_count = 0;
    int compares = 0;
    int cyc = 0;

    drs_dual_role i_drs_dual_role (.clk(clk), .reset(reset), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .phy_stat(phy_stat),
        .host_core_irq(host_core_irq), .slow_wake_clock_tick(slow_tick),
        .phy_ctl(phy_ctl), .shared_irq_pin(shared_irq_pin), .power_down(power_down),
        .local_dp_pullup(local_dp_pullup));
    drs_peer i_drs_peer (.phy_ctl(phy_ctl), .peer_pullup(peer_pullup),
        .peer_vbus(peer_vbus), .peer_id(peer_id), .phy_stat(phy_stat));

    always #10 clk = ~clk;

    task test_done;
        if (fail_count == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            fail_count++;
            test_done;
        end
    end

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // no fixed latency assumed, though pready always comes one cycle into access, even after a wake-up
        do
            @(posedge clk);
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task rchk(input logic [11:0] a, input logic [31:0] exp, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, rd, exp);
    endtask

    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        repeat (3) @(posedge clk);
    endtask

    initial
    begin
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        rchk(12'h000, 32'h0, "control");
        rchk(12'h014, 32'h0, "hwcfg");
        chk("pin", shared_irq_pin, 1'b1);
        rchk(12'h004, 32'h85, "status");
        wr(12'h000, 32'h610);
        rchk(12'h000, 32'h610, "control");
        chk("pullup", local_dp_pullup, 1'b1);
        wr(12'h000, 32'h0);
        rchk(12'h3FC, 32'h0, "unmapped");
        chk("slverr", er, 1'b1);
        wr(12'h008, 32'h7FF);
        peer_pullup <= 1'b0;
        rchk(12'h004, 32'h45, "status");
        wr(12'h000, 32'h10);
        rchk(12'h004, 32'h85, "status");
        rchk(12'h008, 32'hC0, "event");
        wr(12'h00C, 32'h40);
        wr(12'h018, 32'h200);
        chk("pin", shared_irq_pin, 1'b1);
        rchk(12'h01C, 32'h200, "flag");
        rchk(12'h008, 32'hC0, "event");
        rchk(12'h004, 32'h85, "status");
        wr(12'h014, 32'h1);
        chk("pin", shared_irq_pin, 1'b0);
        wr(12'h014, 32'h5);
        chk("pin", shared_irq_pin, 1'b1);
        wr(12'h014, 32'h1);
        wr(12'h008, 32'h40);
        chk("pin", shared_irq_pin, 1'b1);
        wr(12'h010, 32'h3);
        repeat (900) @(posedge clk);
        rchk(12'h008, 32'h80, "event");
        repeat (700) @(posedge clk);
        rchk(12'h008, 32'h480, "event");
        wr(12'h008, 32'h7FF);
        repeat (1600) @(posedge clk);
        rchk(12'h008, 32'h0, "event");
        peer_vbus <= 1'b1;
        wr(12'h020, 32'h1);
        chk("sleep", power_down, 1'b0);
        peer_vbus <= 1'b0;
        wr(12'h008, 32'h7FF);
        wr(12'h00C, 32'h1);
        wr(12'h020, 32'h1);
        chk("sleep", power_down, 1'b1);
        peer_id <= 1'b0;
        repeat (10) @(posedge clk);
        chk("sleep", power_down, 1'b0);
        wr(12'h00C, 32'h0);
        wr(12'h020, 32'h1);
        peer_id <= 1'b1;
        repeat (10) @(posedge clk);
        chk("sleep", power_down, 1'b1);
        apb(1'b0, 12'h020, 32'h0);
        repeat (5) @(posedge clk);
        chk("sleep", power_down, 1'b0);
        test_done;
    end
endmodule

`default_nettype wire
